/* File: fill_counter.sv */
// Purpose: counts slots moved since the last host interrupt
// Assumes: step_i is a one-cycle pulse per slot
// Notes:   saturates so a stalled host cannot wrap it
`include "mailbox_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module fill_counter (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic step_i,
    input  wire logic restart_i,
    output logic      over_o
);
    import mailbox_pkg::*;
    logic [4:0] count;

    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i) begin
            count <= '0;
        end else if (step_i && count != 5'h1f) begin
            count <= count + 5'd1;
        end
    end

    assign over_o = (count > `FILL_THRESHOLD);
endmodule
`default_nettype wire

/* File: flush_timer.sv */
// Purpose: buffer-flush timer with free-running and data-triggered modes
// Assumes: one millisecond tick derived from clk_i
// Notes:   restarts whenever the host interrupt is raised
`include "mailbox_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module flush_timer #(
    parameter int MS_CYCLES = `CYCLES_PER_MS
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] period_i,
    input  wire logic       mode_i,
    input  wire logic       activity_i,
    input  wire logic       restart_i,
    output logic            expire_o
);
    import mailbox_pkg::*;
    logic [31:0] tick_cnt;
    logic [7:0]  ms_cnt;
    logic        armed;
    logic        running;
    logic        tick;

    // Data-triggered mode stays stopped until a character moves
    assign running = (period_i != `FLUSH_DISABLE) && (!mode_i || armed);
    assign tick    = running && (tick_cnt == 32'(MS_CYCLES - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i || !running) begin
            tick_cnt <= '0;
        end else if (tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 32'd1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i || !running) begin
            ms_cnt <= '0;
        end else if (tick) begin
            ms_cnt <= ms_cnt + 8'd1;
        end
    end

    // Activity in the same cycle as a restart still arms the next period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            armed <= 1'b0;
        end else if (activity_i) begin
            armed <= 1'b1;
        end else if (restart_i) begin
            armed <= 1'b0;
        end
    end

    assign expire_o = tick && (ms_cnt + 8'd1 >= period_i);
endmodule
`default_nettype wire

/* File: host_model.sv */
// Purpose: host processor on the mailbox bus
// Assumes: classic Wishbone single cycles
// Notes:   pointers are kept by the caller, which keeps this model stateless
`include "mailbox_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic      [11:0] adr_o,
    output logic      [3:0]  sel_o,
    output logic      [31:0] dat_o
);
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end
    task automatic wb_cycle(input logic w, input logic [11:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'h3, d};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        {cyc_o, stb_o, we_o} <= 3'b000;
    endtask
    task automatic tx_put(input logic [3:0] p, input logic [7:0] c);
        logic [31:0] q;
        do wb_cycle(1'b0, `TX_RING_BASE + {p, 2'b00}, 32'h0, q);
        while (q[15:8] !== 8'h00);
        wb_cycle(1'b1, `TX_RING_BASE + {p, 2'b00}, {16'h0, `FLAG_MARK, c}, q);
    endtask
    task automatic rx_take(input logic [3:0] p, output logic [15:0] word);
        logic [31:0] q;
        do wb_cycle(1'b0, `RX_RING_BASE + {p, 2'b00}, 32'h0, q);
        while (q[15:8] === 8'h00);
        word = q[15:0];
        wb_cycle(1'b1, `RX_RING_BASE + {p, 2'b00}, 32'h0, q);
    endtask
endmodule
`default_nettype wire

/* File: host_port_ring_buffer_mailbox.sv */
// Purpose: shared transmit/receive ring buffers with valid-flag handshake
// Assumes: host reaches rings and registers over classic Wishbone
// Notes:   one clock, synchronous active-high reset
`include "mailbox_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module host_port_ring_buffer_mailbox #(
    parameter int MS_CYCLES = `CYCLES_PER_MS
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [11:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             host_interrupt_request_o,
    input  wire logic [7:0]  rx_char_i,
    input  wire logic        rx_valid_i,
    output logic             rx_ready_o,
    output logic      [7:0]  tx_char_o,
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    output logic             command_mode_o,
    output logic             cts_o,
    output logic             dsr_o,
    output logic             dcd_o,
    output logic             ri_o,
    output logic             off_hook_o,
    input  wire logic        rts_i,
    input  wire logic        dtr_i
);
    import mailbox_pkg::*;

    // Two rings of sixteen words; the flag byte is the only ownership record
    slot_t     tx_ring [`RING_DEPTH];
    slot_t     rx_ring [`RING_DEPTH];
    ring_idx_t tx_ptr;
    ring_idx_t rx_ptr;
    engine_e   tx_state;
    engine_e   rx_state;
    logic [7:0] flush_period;
    logic       flush_mode;
    logic       host_sel;
    logic       irq_bit;
    logic       raise;
    logic       rx_over;
    logic       tx_over;
    logic       flush_expire;
    logic       rx_fill;
    logic       tx_take;
    logic       bus_req;
    logic       bus_wr;
    logic       bus_rd;
    logic       tx_hit;
    logic       rx_hit;
    logic [31:0] next_dat;
    logic [7:0]  rx_hold;

    // Ring decode is used by both the write path and the read mux
    function automatic logic ring_hit(input logic [11:0] adr, input logic [11:0] base);
        ring_hit = (adr[11:6] == base[11:6]) && (adr[1:0] == 2'b00);
    endfunction

    function automatic ring_idx_t slot_of(input logic [11:0] adr);
        slot_of = adr[5:2];
    endfunction

    assign bus_req = cyc_i && stb_i && !ack_o;
    assign bus_wr  = bus_req && we_i;
    assign bus_rd  = bus_req && !we_i;
    assign tx_hit  = ring_hit(adr_i, `TX_RING_BASE);
    assign rx_hit  = ring_hit(adr_i, `RX_RING_BASE);

    // RTS and DTR are deliberately left unread
    assign cts_o      = 1'b1;
    assign dsr_o      = 1'b0;
    assign dcd_o      = 1'b0;
    assign ri_o       = 1'b0;
    assign off_hook_o = 1'b0;

    // Every request, mapped or not, is answered one cycle later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req;
        end
    end

    // Host writes land in the ring unless the device engine owns the slot this cycle
    generate
        for (genvar i = 0; i < `RING_DEPTH; i++) begin : g_slot
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    tx_ring[i] <= '0;
                end else if (tx_take && tx_ptr == ring_idx_t'(i)) begin
                    tx_ring[i] <= '0;
                end else if (bus_wr && tx_hit && slot_of(adr_i) == ring_idx_t'(i)) begin
                    if (sel_i[0]) tx_ring[i][7:0]  <= dat_i[7:0];
                    if (sel_i[1]) tx_ring[i][15:8] <= dat_i[15:8];
                end
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    rx_ring[i] <= '0;
                end else if (rx_fill && rx_ptr == ring_idx_t'(i)) begin
                    rx_ring[i] <= {`FLAG_MARK, rx_hold};
                end else if (bus_wr && rx_hit && slot_of(adr_i) == ring_idx_t'(i)) begin
                    if (sel_i[0]) rx_ring[i][7:0]  <= dat_i[7:0];
                    if (sel_i[1]) rx_ring[i][15:8] <= dat_i[15:8];
                end
            end
        end
    endgenerate

    // Transmit engine: consume flagged slots in ascending order
    assign tx_take    = (tx_state == ENG_WRITE) && tx_ready_i;
    assign tx_valid_o = (tx_state == ENG_WRITE);
    assign tx_char_o  = tx_ring[tx_ptr][7:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_state <= ENG_IDLE;
        end else begin
            case (tx_state)
                ENG_IDLE:  tx_state <= ENG_CHECK;
                ENG_CHECK: tx_state <= (tx_ring[tx_ptr][15:8] != 8'h00) ? ENG_WRITE : ENG_CHECK;
                ENG_WRITE: tx_state <= tx_ready_i ? ENG_CHECK : ENG_WRITE;
                default:   tx_state <= ENG_IDLE;
            endcase
        end
    end

    // Four-bit pointers wrap at the ring depth without extra logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_ptr <= '0;
        end else if (tx_take) begin
            tx_ptr <= tx_ptr + 4'd1;
        end
    end

    // Receive engine: accept a character only when the current slot is free
    assign rx_ready_o = (rx_state == ENG_CHECK) && (rx_ring[rx_ptr][15:8] == 8'h00);
    assign rx_fill    = (rx_state == ENG_WRITE);

    // Character is latched at acceptance; the slot is written the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_hold <= '0;
        end else if (rx_valid_i && rx_ready_o) begin
            rx_hold <= rx_char_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_state <= ENG_IDLE;
        end else begin
            case (rx_state)
                ENG_IDLE:  rx_state <= ENG_CHECK;
                ENG_CHECK: rx_state <= (rx_valid_i && rx_ready_o) ? ENG_WRITE : ENG_CHECK;
                ENG_WRITE: rx_state <= ENG_CHECK;
                default:   rx_state <= ENG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_ptr <= '0;
        end else if (rx_fill) begin
            rx_ptr <= rx_ptr + 4'd1;
        end
    end

    // Configuration: flush period, flush mode and command source select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flush_period <= `FLUSH_PERIOD_RST;
            flush_mode   <= `FLUSH_MODE_RST;
            host_sel     <= 1'b1;
        end else if (bus_wr && adr_i == `FLUSH_OFFSET) begin
            if (sel_i[0]) flush_period <= dat_i[7:0];
            if (sel_i[1]) flush_mode   <= dat_i[8];
        end else if (bus_wr && adr_i == `CTRL_OFFSET && sel_i[0]) begin
            host_sel <= dat_i[0];
        end
    end

    // Command mode is the only mode this block knows; the parser lives elsewhere
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            command_mode_o <= 1'b1;
        end else begin
            command_mode_o <= 1'b1;
        end
    end

    // Separate counts per direction, so either threshold raises on its own
    fill_counter u_rx_count (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .step_i    (rx_fill),
        .restart_i (raise),
        .over_o    (rx_over)
    );

    fill_counter u_tx_count (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .step_i    (tx_take),
        .restart_i (raise),
        .over_o    (tx_over)
    );

    flush_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_flush (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .period_i   (flush_period),
        .mode_i     (flush_mode),
        .activity_i (rx_fill || tx_take),
        .restart_i  (raise),
        .expire_o   (flush_expire)
    );

    assign raise = rx_over || tx_over || flush_expire;

    // New cause wins over a host clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_bit <= 1'b0;
        end else if (raise) begin
            irq_bit <= 1'b1;
        end else if (bus_wr && adr_i == `STATUS_OFFSET && sel_i[0] && dat_i[`STAT_IRQ_BIT]) begin
            irq_bit <= 1'b0;
        end
    end

    assign host_interrupt_request_o = irq_bit;

    // Unmapped addresses read as zero and ignore writes
    always_comb begin
        next_dat = 32'h0000_0000;
        if (tx_hit) begin
            next_dat = {16'h0000, tx_ring[slot_of(adr_i)]};
        end else if (rx_hit) begin
            next_dat = {16'h0000, rx_ring[slot_of(adr_i)]};
        end else if (adr_i == `CTRL_OFFSET) begin
            next_dat = {31'h0, host_sel};
        end else if (adr_i == `STATUS_OFFSET) begin
            next_dat = {30'h0, command_mode_o, irq_bit};
        end else if (adr_i == `FLUSH_OFFSET) begin
            next_dat = {23'h0, flush_mode, flush_period};
        end else if (adr_i == `POINTER_OFFSET) begin
            next_dat = {20'h0, tx_ptr, 4'h0, rx_ptr};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else if (bus_rd) begin
            dat_o <= next_dat;
        end
    end
endmodule
`default_nettype wire

/* File: host_port_ring_buffer_mailbox_test.sv */
// Purpose: self-checking bench for the ring buffer mailbox
// Assumes: millisecond shortened to 10 clocks
// Notes: the bench pointers are the host's own, from slot 0
`include "mailbox_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module host_port_ring_buffer_mailbox_test;
    logic clk_i, rst_i, cyc, stb, we, ack, irq, rx_valid_i, rx_ready, tx_valid, tx_ready_i;
    logic cts, dsr, dcd, ri, hook, cmd;
    logic [11:0] adr;
    logic [3:0]  sel, rp, tp;
    logic [31:0] wdat, rdat, q, rnd, rs;
    logic [15:0] w;
    logic [7:0]  rx_char_i, tx_char;
    logic [7:0]  rx_q[$], tx_exp[$], tx_got[$];
    int miscompares, n_compared, cycles, i, k;
    host_port_ring_buffer_mailbox #(.MS_CYCLES(10)) host_port_ring_buffer_mailbox_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .host_interrupt_request_o(irq),
        .rx_char_i(rx_char_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready),
        .tx_char_o(tx_char), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready_i),
        .command_mode_o(cmd), .cts_o(cts), .dsr_o(dsr), .dcd_o(dcd), .ri_o(ri),
        .off_hook_o(hook), .rts_i(1'b0), .dtr_i(1'b0));
    host_model host_model_inst (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared=%0d mismatched=%0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host_model_inst.wb_cycle(1'b1, a, d, q);
    endtask
    task automatic rx_send();
        @(posedge clk_i);
        rnd = xs(rnd);
        rx_char_i <= rnd[7:0];
        rx_valid_i <= 1'b1;
        rx_q.push_back(rnd[7:0]);
        do @(posedge clk_i); while (rx_ready !== 1'b1);
        rx_valid_i <= 1'b0;
    endtask
    task automatic rx_burst(input int n, input logic [31:0] irq_exp);
        for (k = 0; k < n; k++) rx_send();
        for (k = 0; k < n; k++) begin
            host_model_inst.rx_take(rp, w);
            rp++;
            check({16'h0, w}, {16'h0, `FLAG_MARK, rx_q.pop_front()});
        end
        @(negedge clk_i);
        check({31'h0, irq}, irq_exp);
        wr(`STATUS_OFFSET, 32'h1);
    endtask
    task automatic wait_irq(input int n, input logic [31:0] exp);
        for (k = 0; k < n && irq !== 1'b1; k++) @(negedge clk_i);
        check({31'h0, irq}, exp);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        rs <= xs(rs);
        tx_ready_i <= rs[0];
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    always @(negedge clk_i) begin
        if (!rst_i && tx_valid === 1'b1 && tx_ready_i === 1'b1) tx_got.push_back(tx_char);
    end
    initial begin
        {rst_i, rx_valid_i, rx_char_i, tx_ready_i, rp, tp, cycles} = {1'b1, 18'h0, 32'h0};
        rnd = 32'hc7927438;
        rs = 32'hc7927438;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        host_model_inst.wb_cycle(1'b0, `FLUSH_OFFSET, 32'h0, q);
        check(q, 32'h0000000a);
        host_model_inst.wb_cycle(1'b0, `CTRL_OFFSET, 32'h0, q);
        check(q, 32'h00000001);
        wr(`FLUSH_OFFSET, 32'hff);
        for (i = 0; i < 33; i++) begin
            host_model_inst.wb_cycle(1'b0, i == 32 ? 12'hffc : (i < 16 ? `TX_RING_BASE
                : `RX_RING_BASE) + 12'(4 * (i % 16)), 32'h0, q);
            check(q, 32'h0);
        end
        check({26'h0, cts, dsr, dcd, ri, hook, cmd}, 32'h21);
        rx_burst(9, 32'h1);
        rx_burst(8, 32'h0);
        for (i = 0; i < 9; i++) begin
            rnd = xs(rnd);
            tx_exp.push_back(rnd[7:0]);
            host_model_inst.tx_put(tp, rnd[7:0]);
            tp++;
        end
        while (tx_got.size() < 9) @(negedge clk_i);
        for (i = 0; i < 9; i++) begin
            check({24'h0, tx_got.pop_front()}, {24'h0, tx_exp.pop_front()});
            host_model_inst.wb_cycle(1'b0, `TX_RING_BASE + 12'(4 * i), 32'h0, q);
            check(q, 32'h0);
        end
        @(negedge clk_i);
        check({31'h0, irq}, 32'h1);
        wr(`FLUSH_OFFSET, 32'h2);
        wr(`STATUS_OFFSET, 32'h1);
        wait_irq(40, 32'h1);
        wr(`FLUSH_OFFSET, 32'h102);
        wr(`STATUS_OFFSET, 32'h1);
        wait_irq(60, 32'h0);
        rx_send();
        wait_irq(40, 32'h1);
        wr(`FLUSH_OFFSET, 32'hff);
        wr(`STATUS_OFFSET, 32'h1);
        wait_irq(60, 32'h0);
        host_model_inst.wb_cycle(1'b0, `POINTER_OFFSET, 32'h0, q);
        check(q, {20'h0, tp, 4'h0, rp + 4'd1});
        print_verdict();
    end
endmodule
`default_nettype wire

/* File: mailbox_assertions.sv */
// Purpose: port checks for the ring buffer mailbox
// Assumes: single clock, synchronous active-high reset
// Notes:   helper counts restart on each interrupt rise; the design's restart on every raise cause
`include "mailbox_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module mailbox_assertions #(
    parameter int MS_CYCLES = 10
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [11:0] adr_i,
    input wire logic        ack_o,
    input wire logic        host_interrupt_request_o,
    input wire logic        rx_valid_i,
    input wire logic        rx_ready_o,
    input wire logic        tx_valid_o,
    input wire logic        tx_ready_i,
    input wire logic        command_mode_o,
    input wire logic        cts_o,
    input wire logic        dsr_o,
    input wire logic        dcd_o,
    input wire logic        ri_o,
    input wire logic        off_hook_o
);
    logic       irq_q;
    logic       irq_rise;
    logic [4:0] rx_cnt;
    logic [4:0] tx_cnt;
    assign irq_rise = host_interrupt_request_o && !irq_q;
    always_ff @(posedge clk_i) begin
        irq_q <= !rst_i && host_interrupt_request_o;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || irq_rise) begin
            rx_cnt <= 5'h00;
        end else if (rx_valid_i && rx_ready_o) begin
            rx_cnt <= rx_cnt + 5'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || irq_rise) begin
            tx_cnt <= 5'h00;
        end else if (tx_valid_o && tx_ready_i) begin
            tx_cnt <= tx_cnt + 5'h01;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    line_levels_a: assert property (cts_o && !dsr_o && !dcd_o && !ri_o && !off_hook_o)
        else $error("modem line outputs off their fixed levels");
    cmd_mode_a: assert property (command_mode_o)
        else $error("command mode not held");
    bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus answer not a single pulse one cycle later");
    rx_gap_a: assert property (rx_valid_i && rx_ready_o |=> !rx_ready_o)
        else $error("receive slot offered again before its flag was set");
    tx_gap_a: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
        else $error("transmit slot offered again after it was taken");
    rx_irq_a: assert property (rx_valid_i && rx_ready_o && rx_cnt == 5'h08
        |-> ##[1:3] host_interrupt_request_o) else $error("no interrupt after ninth fill");
    tx_irq_a: assert property (tx_valid_o && tx_ready_i && tx_cnt == 5'h08
        |-> ##[1:3] host_interrupt_request_o) else $error("no interrupt after ninth take");
    irq_hold_a: assert property (host_interrupt_request_o &&
        !(cyc_i && stb_i && we_i && adr_i == `STATUS_OFFSET) |=> host_interrupt_request_o)
        else $error("interrupt dropped without a host clear");
    rx_fill_c: cover property (rx_valid_i && rx_ready_o);
    tx_take_c: cover property (tx_valid_o && tx_ready_i);
    irq_rise_c: cover property (irq_rise);
endmodule
bind host_port_ring_buffer_mailbox mailbox_assertions #(.MS_CYCLES(MS_CYCLES))
    mailbox_assertions_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .ack_o(ack_o), .host_interrupt_request_o(host_interrupt_request_o),
    .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .command_mode_o(command_mode_o), .cts_o(cts_o),
    .dsr_o(dsr_o), .dcd_o(dcd_o), .ri_o(ri_o), .off_hook_o(off_hook_o));
`default_nettype wire

/* File: mailbox_consts.svh */
// Purpose: constants of the host port ring buffer mailbox
// Assumes: 32-bit classic Wishbone, word-aligned byte addresses
// Notes:   definitions only
`ifndef MAILBOX_CONSTS_SVH
`define MAILBOX_CONSTS_SVH
`define RING_DEPTH        16
`define RING_IDX_W        4
`define FILL_THRESHOLD    5'd8
`define TX_RING_BASE      12'h080
`define RX_RING_BASE      12'h180
`define CTRL_OFFSET       12'h000
`define STATUS_OFFSET     12'h004
`define FLUSH_OFFSET      12'h008
`define POINTER_OFFSET    12'h00c
`define FLUSH_PERIOD_RST  8'd10
`define FLUSH_DISABLE     8'd255
`define FLUSH_MODE_RST    1'b0
`define FLAG_MARK         8'h3f
`define CLK_MHZ           250
`define MS_NS             1000000
`define CLK_NS            4
`define CYCLES_PER_MS     (`MS_NS / `CLK_NS)
`define STAT_IRQ_BIT      0
`define STAT_CMD_BIT      1
`endif

/* File: mailbox_pkg.sv */
// Purpose: types of the host port ring buffer mailbox
// Assumes: nothing
// Notes:   numbers live in mailbox_consts.svh
package mailbox_pkg;
    typedef logic [15:0] slot_t;
    typedef logic [3:0]  ring_idx_t;
    typedef enum logic [1:0] {
        ENG_IDLE  = 2'b00,
        ENG_CHECK = 2'b01,
        ENG_WRITE = 2'b10
    } engine_e;
endpackage
